// ### ftp_field_model.sv
// Trigger sources and input wiring at the block's pins
`timescale 1ns/1ps
module ftp_field_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Bench requests
  input  wire logic [3:0] fire,
  input  wire logic [5:0] level,
  // Pins
  output logic      [3:0] trig_in,
  output logic      [5:0] din
);
  logic [2:0] hold;
  // Stretched so the two-flop synchroniser cannot miss it
  always_ff @(posedge clock) begin
    din <= level;
    if (srst || hold == 3'h1) begin
      trig_in <= 4'h0;
    end
    if (|fire) begin
      trig_in <= fire;
    end
    if (srst) begin
      hold <= 3'h0;
    end else begin
      hold <= (|fire) ? 3'h5 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
    end
  end
endmodule : ftp_field_model

// ### ftp_pkg.sv
// Package for the four-channel triggered PWM block: register map, fields, timing
package ftp_pkg;
  localparam int CLK_HZ      = 40_000_000;
  localparam int US_PER_S    = 1_000_000;
  localparam int TICK_CYCLES = CLK_HZ / US_PER_S;
  localparam int TICK_W      = 6;

  localparam int NUM_CH      = 4;
  localparam int DUTY_W      = 8;
  localparam int TIME_W      = 22;
  localparam int DOUT_W      = 12;
  localparam int DIN_W       = 6;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;

  // Per-channel register block: channel index in addr[5:4], register in addr[3:2]
  localparam logic [1:0] REG_DUTY   = 2'h0;
  localparam logic [1:0] REG_DELAY  = 2'h1;
  localparam logic [1:0] REG_PERIOD = 2'h2;
  localparam logic [1:0] REG_CTRL   = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_DOUT = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_DIN  = 8'h44;
  localparam logic [1:0] CH_SPACE_HI = 2'h0;

  // Control register fields
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_TRIG    = 1;
  localparam int CTRL_CONT    = 2;
  localparam int CTRL_RESET   = 3;
  localparam int CTRL_STATE_L = 4;

  // Reset values
  localparam logic [DUTY_W-1:0] DUTY_RST   = 8'h00;
  localparam logic [TIME_W-1:0] DELAY_RST  = 22'h000000;
  localparam int                PERIOD_RST_MS = 1000;
  localparam logic [TIME_W-1:0] PERIOD_RST = TIME_W'(PERIOD_RST_MS * 1000);
  localparam logic [DOUT_W-1:0] DOUT_RST   = 12'h000;

  typedef enum logic [1:0] {
    FTP_IDLE  = 2'b00,
    FTP_DELAY = 2'b01,
    FTP_OUT   = 2'b11
  } ftp_state_e;
endpackage : ftp_pkg

// ### ftp_top.sv
// Four triggered PWM channels with digital output latch and input port
//
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module ftp_top
  import ftp_pkg::*;
(
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         srst,
  // Register port
  input  wire logic [ftp_pkg::ADDR_W-1:0]   addr,
  input  wire logic [ftp_pkg::DATA_W-1:0]   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [ftp_pkg::DATA_W-1:0]   rdata,
  // Pins
  input  wire logic [ftp_pkg::NUM_CH-1:0]   trig_in,
  input  wire logic [ftp_pkg::DIN_W-1:0]    din,
  output logic      [ftp_pkg::NUM_CH-1:0]   pwm_out,
  output logic      [ftp_pkg::DOUT_W-1:0]   dout
);
  import ftp_pkg::*;

  // Input synchronisers
  logic [NUM_CH-1:0] trig_s1, trig_s2, trig_s3;
  logic [DIN_W-1:0]  din_s1, din_s2;
  always_ff @(posedge clock) begin
    trig_s1 <= trig_in;
    trig_s2 <= trig_s1;
    trig_s3 <= trig_s2;
    din_s1  <= din;
    din_s2  <= din_s1;
  end

  // Microsecond tick and PWM phase shared by all channels
  logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
  logic              us_tick, next_us_tick;
  logic [DUTY_W-1:0] phase, next_phase;
  always_comb begin
    next_tick_cnt = tick_cnt + 1'b1;
    next_us_tick  = 1'b0;
    next_phase    = phase;
    if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      next_tick_cnt = '0;
      next_us_tick  = 1'b1;
    end
    // 255 steps per PWM cycle, so duty 255 is fully on
    if (us_tick) begin
      next_phase = (phase == 8'hfe) ? 8'h00 : phase + 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      tick_cnt <= '0;
      us_tick  <= 1'b0;
      phase    <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
      us_tick  <= next_us_tick;
      phase    <= next_phase;
    end
  end

  // Address decode
  logic       ch_sel;
  logic [1:0] ch_idx;
  logic [1:0] reg_idx;
  assign ch_sel  = (addr[7:6] == CH_SPACE_HI) && (addr[1:0] == 2'h0);
  assign ch_idx  = addr[5:4];
  assign reg_idx = addr[3:2];

  // Digital output latch
  logic [DOUT_W-1:0] dout_q, next_dout_q;
  always_comb begin
    next_dout_q = dout_q;
    if (wr && addr == ADDR_DOUT) begin
      next_dout_q = wdata[DOUT_W-1:0];
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      dout_q <= DOUT_RST;
    end else begin
      dout_q <= next_dout_q;
    end
  end
  assign dout = dout_q;

  // Per-channel state
  logic [DUTY_W-1:0] duty   [NUM_CH];
  logic [TIME_W-1:0] delay  [NUM_CH];
  logic [TIME_W-1:0] period [NUM_CH];
  logic [NUM_CH-1:0] en, trig_mode, cont;
  ftp_state_e        state  [NUM_CH];
  logic [DATA_W-1:0] ch_rd  [NUM_CH];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [DUTY_W-1:0] next_duty;
      logic [TIME_W-1:0] next_delay, next_period, tmr, next_tmr;
      logic              next_en, next_trig, next_cont, next_pwm, pwm_q;
      logic              wr_ch, trig_edge;
      ftp_state_e        next_state;

      assign wr_ch     = wr && ch_sel && (ch_idx == 2'(g));
      assign trig_edge = trig_s2[g] && !trig_s3[g];

      always_comb begin
        next_duty   = duty[g];
        next_delay  = delay[g];
        next_period = period[g];
        next_en     = en[g];
        next_trig   = trig_mode[g];
        next_cont   = cont[g];
        next_state  = state[g];
        next_tmr    = tmr;
        if (wr_ch) begin
          unique case (reg_idx)
            REG_DUTY:   next_duty   = wdata[DUTY_W-1:0];
            REG_DELAY:  next_delay  = wdata[TIME_W-1:0];
            REG_PERIOD: next_period = wdata[TIME_W-1:0];
            REG_CTRL: begin
              next_en   = wdata[CTRL_ENABLE];
              next_trig = wdata[CTRL_TRIG];
              next_cont = wdata[CTRL_CONT];
            end
          endcase
        end
        // Trigger sequencer, timers count whole microseconds
        if (!en[g] || !trig_mode[g]) begin
          next_state = FTP_IDLE;
          next_tmr   = '0;
        end else begin
          unique case (state[g])
            FTP_IDLE: if (trig_edge) begin
              next_state = FTP_DELAY;
              next_tmr   = '0;
            end
            FTP_DELAY: if (tmr >= delay[g]) begin
              next_state = FTP_OUT;
              next_tmr   = '0;
            end else if (us_tick) begin
              next_tmr = tmr + 1'b1;
            end
            FTP_OUT: if (tmr >= period[g]) begin
              next_state = cont[g] ? FTP_DELAY : FTP_IDLE;
              next_tmr   = '0;
            end else if (us_tick) begin
              next_tmr = tmr + 1'b1;
            end
            default: begin
              next_state = FTP_IDLE;
              next_tmr   = '0;
            end
          endcase
        end
        // Channel reset strobe overrides a write in the same cycle
        if (wr_ch && reg_idx == REG_CTRL && wdata[CTRL_RESET]) begin
          next_duty   = DUTY_RST;
          next_en     = 1'b0;
          next_trig   = 1'b0;
          next_cont   = 1'b0;
          next_delay  = DELAY_RST;
          next_period = PERIOD_RST;
          next_state  = FTP_IDLE;
          next_tmr    = '0;
        end
        next_pwm = en[g] && (phase < duty[g] || duty[g] == 8'hff)
                   && (!trig_mode[g] || state[g] == FTP_OUT);
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          duty[g]      <= DUTY_RST;
          delay[g]     <= DELAY_RST;
          period[g]    <= PERIOD_RST;
          en[g]        <= 1'b0;
          trig_mode[g] <= 1'b0;
          cont[g]      <= 1'b0;
          state[g]     <= FTP_IDLE;
          tmr          <= '0;
          pwm_q        <= 1'b0;
        end else begin
          duty[g]      <= next_duty;
          delay[g]     <= next_delay;
          period[g]    <= next_period;
          en[g]        <= next_en;
          trig_mode[g] <= next_trig;
          cont[g]      <= next_cont;
          state[g]     <= next_state;
          tmr          <= next_tmr;
          pwm_q        <= next_pwm;
        end
      end
      assign pwm_out[g] = pwm_q;

      always_comb begin
        ch_rd[g] = '0;
        unique case (reg_idx)
          REG_DUTY:   ch_rd[g][DUTY_W-1:0] = duty[g];
          REG_DELAY:  ch_rd[g][TIME_W-1:0] = delay[g];
          REG_PERIOD: ch_rd[g][TIME_W-1:0] = period[g];
          REG_CTRL: begin
            ch_rd[g][CTRL_ENABLE]              = en[g];
            ch_rd[g][CTRL_TRIG]                = trig_mode[g];
            ch_rd[g][CTRL_CONT]                = cont[g];
            ch_rd[g][CTRL_STATE_L+1:CTRL_STATE_L] = state[g];
          end
        endcase
      end
    end
  endgenerate

  // Read data, valid only in the cycle after the strobe
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (rd) begin
      if (ch_sel) begin
        next_rdata = ch_rd[ch_idx];
      end else if (addr == ADDR_DOUT) begin
        next_rdata = {20'h00000, dout_q};
      end else if (addr == ADDR_DIN) begin
        next_rdata = {26'h0000000, din_s2};
      end
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule : ftp_top

// ### ftp_top_monitor.sv
// Port assertions for the triggered PWM block
`timescale 1ns/1ps
module ftp_top_monitor
  import ftp_pkg::*;
(
  // Clock and reset
  input wire logic                       clock,
  input wire logic                       srst,
  // Register port
  input wire logic [ftp_pkg::ADDR_W-1:0] addr,
  input wire logic [ftp_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [ftp_pkg::DATA_W-1:0] rdata,
  // Pins
  input wire logic [ftp_pkg::NUM_CH-1:0] trig_in,
  input wire logic [ftp_pkg::DIN_W-1:0]  din,
  input wire logic [ftp_pkg::NUM_CH-1:0] pwm_out,
  input wire logic [ftp_pkg::DOUT_W-1:0] dout
);
  logic rst_d;
  always_ff @(posedge clock) rst_d <= srst;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_reset_quiet: assert property (rst_d |-> pwm_out == '0 && dout == '0 && rdata == '0)
    else $error("outputs not cleared by reset");
  a_read_idle: assert property (!rd |=> rdata == '0)
    else $error("read data without a read");
  a_dout_write: assert property (wr && addr == ADDR_DOUT |=> dout == $past(wdata[11:0]))
    else $error("output latch did not take write");
  a_dout_hold: assert property (!(wr && addr == ADDR_DOUT) |=> $stable(dout))
    else $error("output latch changed unasked");
  a_dout_read: assert property (rd && addr == ADDR_DOUT |=> rdata == {20'h0, $past(dout)})
    else $error("output latch read wrong");
  a_din_width: assert property (rd && addr == ADDR_DIN |=> rdata[31:6] == '0)
    else $error("input word too wide");
  a_duty_readback: assert property (wr && addr == 8'h00 ##2 rd && addr == 8'h00
    |=> rdata == {24'h0, $past(wdata[7:0], 3)}) else $error("duty read back wrong");
  a_ctrl_reset_bit: assert property (rd && addr[3:2] == REG_CTRL |=> !rdata[CTRL_RESET])
    else $error("channel reset bit reads one");
  a_delay_width: assert property (rd && addr[3:0] == 4'h4 |=> rdata[31:22] == '0)
    else $error("delay wider than 22 bits");
endmodule : ftp_top_monitor

bind ftp_top ftp_top_monitor u_mon (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .trig_in(trig_in), .din(din), .pwm_out(pwm_out), .dout(dout));

// ### test_ftp_top.sv
// Self-checking bench for the four-channel triggered PWM block
`timescale 1ns/1ps
module test_ftp_top;
  import ftp_pkg::*;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  trig_in;
  logic [3:0]  fire;
  logic [3:0]  pwm_out;
  logic [5:0]  din;
  logic [5:0]  level;
  logic [11:0] dout;
  logic        clock;
  logic        srst;
  logic        wr;
  logic        rd;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          t;
  // Address, write data, expected read-back
  logic [71:0] rows [9] = '{{8'h00, 32'h1ab, 32'hab}, {8'h30, 32'hff, 32'hff},
    {8'h14, 32'h3fffff, 32'h3fffff}, {8'h18, 32'hffffffff, 32'h3fffff}, {8'h40, 32'hfff, 32'hfff},
    {8'h40, 32'ha5a, 32'ha5a}, {8'h41, 32'h1234, 32'h0}, {8'h50, 32'hff, 32'h0},
    {8'h44, 32'h3f, 32'h0}};

  ftp_top uut (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .trig_in(trig_in), .din(din), .pwm_out(pwm_out), .dout(dout));
  ftp_field_model field (.clock(clock), .srst(srst), .fire(fire), .level(level),
    .trig_in(trig_in), .din(din));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rd_chk

  // Bounded so a stuck output ends as a mismatch, not a hang
  task automatic wait_pwm(input int ch, input logic lvl, output int n);
    n = 0;
    while (pwm_out[ch] !== lvl && n < 1000) begin
      @(posedge clock);
      #1 n++;
    end
  endtask : wait_pwm

  task automatic pulse_ch2;
    fire <= 4'h4;
    @(posedge clock);
    fire <= 4'h0;
  endtask : pulse_ch2

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    fire = 4'h0;
    level = 6'h00;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    foreach (rows[i]) begin
      wr_reg(rows[i][71:64], rows[i][63:32]);
      rd_chk(rows[i][71:64], rows[i][31:0]);
    end
    chk({20'h0, dout}, 32'ha5a);
    wr_reg(8'h00, 32'h80);
    wr_reg(8'h0c, 32'h1);
    repeat (3) @(posedge clock);
    t = 0;
    // One whole 255 us frame, so the phase at start does not matter
    repeat (10200) begin
      @(posedge clock);
      #1 t += (pwm_out[0] === 1'b1);
    end
    chk(t, 32'd5120);
    wr_reg(8'h00, 32'h0);
    repeat (3) @(posedge clock);
    chk(pwm_out[0], 32'h0);
    wr_reg(8'h24, 32'h2);
    wr_reg(8'h28, 32'h3);
    wr_reg(8'h20, 32'hff);
    wr_reg(8'h2c, 32'h3);
    pulse_ch2();
    wait_pwm(2, 1'b1, t);
    chk(t >= 40 && t <= 130, 32'h1);
    wait_pwm(2, 1'b0, t);
    chk(t >= 75 && t <= 130, 32'h1);
    rd_chk(8'h2c, 32'h3);
    wr_reg(8'h2c, 32'h7);
    pulse_ch2();
    wait_pwm(2, 1'b1, t);
    wait_pwm(2, 1'b0, t);
    wait_pwm(2, 1'b1, t);
    chk(t >= 40 && t <= 130, 32'h1);
    wr_reg(8'h10, 32'h55);
    wr_reg(8'h1c, 32'h0f);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h18, 32'hf4240);
    rd_chk(8'h1c, 32'h0);
    level <= 6'h2a;
    repeat (4) @(posedge clock);
    rd_chk(8'h44, 32'h2a);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    chk({20'h0, dout}, 32'h0);
    rd_chk(8'h28, 32'hf4240);
    wrap_up();
  end
endmodule : test_ftp_top
